// >>> shared/plam_map.svh
// constants of the logic array block: geometry, register offsets, reset values
`ifndef PLAM_MAP_SVH
`define PLAM_MAP_SVH
`define PLAM_N_IN        12
`define PLAM_N_CELL      10
`define PLAM_N_ARR       22
`define PLAM_N_LINE      44
`define PLAM_N_TERM      132
`define PLAM_MIN_SUM     8
`define PLAM_TERM_AR     0
`define PLAM_TERM_SP     131
`define PLAM_CELL_RST    44'hfff_ffff_ffff
`define PLAM_CELL_WORDS  10'h108
`define PLAM_CFG_ADDR    12'h800
`define PLAM_STAT_ADDR   12'h804
`define PLAM_CFG_RST     20'h0_0000
`define PLAM_RESP_OK     2'b00
`define PLAM_RESP_ERR    2'b10
`endif

// >>> shared/plam_pkg.sv
// types of the logic array block
`include "plam_map.svh"
package plam_pkg;
	typedef struct packed {
		logic [`PLAM_N_CELL-1:0] pol_high;
		logic [`PLAM_N_CELL-1:0] registered;
	} plam_cfg_t;
	typedef logic [`PLAM_N_LINE-1:0] plam_line_t;
endpackage

// >>> rtl/plam_top.sv
// sum-of-products logic array with ten output cells and an axi4-lite programming port
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "plam_map.svh"
module plam_top
	import plam_pkg::*;
(
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [11:0]             s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [11:0]             s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    clk_pin,
	input  wire logic [`PLAM_N_IN-1:0]   in_pin,
	input  wire logic [`PLAM_N_CELL-1:0] io_in,
	output logic      [`PLAM_N_CELL-1:0] io_out,
	output logic      [`PLAM_N_CELL-1:0] io_oe
);
	function automatic int sum_count(input int i);
		return `PLAM_MIN_SUM + 2 * ((i < 5) ? i : 9 - i);
	endfunction
	function automatic int cell_base(input int i);
		int b;
		b = 1;
		for (int k = 0; k < i; k++) begin
			b = b + sum_count(k) + 1;
		end
		return b;
	endfunction
	function automatic logic [31:0] merge32(input logic [31:0] o, input logic [31:0] d,
			input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return (o & ~m) | (d & m);
	endfunction

	plam_line_t                cell_mem [0:`PLAM_N_TERM-1];
	plam_cfg_t                 cfg_reg;
	logic [`PLAM_N_CELL-1:0]   state_reg;
	logic [`PLAM_N_CELL-1:0]   out_reg;
	logic [`PLAM_N_CELL-1:0]   oe_reg;
	logic [`PLAM_N_IN-1:0]     in_s1_reg;
	logic [`PLAM_N_IN-1:0]     in_s2_reg;
	logic [`PLAM_N_CELL-1:0]   io_s1_reg;
	logic [`PLAM_N_CELL-1:0]   io_s2_reg;
	logic                      clk_s1_reg;
	logic                      clk_s2_reg;
	logic                      clk_s3_reg;
	logic                      awready_reg;
	logic                      wready_reg;
	logic                      bvalid_reg;
	logic [1:0]                bresp_reg;
	logic                      arready_reg;
	logic                      rvalid_reg;
	logic [1:0]                rresp_reg;
	logic [31:0]               rdata_reg;
	logic [11:0]               awaddr_reg;
	logic [31:0]               wdata_reg;
	logic [3:0]                wstrb_reg;

	wire [`PLAM_N_CELL-1:0]    fb_vec;
	wire [`PLAM_N_ARR-1:0]     arr_in;
	plam_line_t                lines;
	wire [`PLAM_N_TERM-1:0]    term_vec;
	wire [`PLAM_N_CELL-1:0]    sum_vec;
	wire [`PLAM_N_CELL-1:0]    oe_term;
	wire [`PLAM_N_CELL-1:0]    q_vec;
	wire [`PLAM_N_CELL-1:0]    out_next;
	wire [`PLAM_N_CELL-1:0]    state_next;
	wire                       ar_term;
	wire                       sp_term;
	wire                       clk_rise;

	// pin inputs, two flops before the array reads them
	always_ff @(posedge aclk) begin
		in_s1_reg  <= in_pin;
		in_s2_reg  <= in_s1_reg;
		io_s1_reg  <= io_in;
		io_s2_reg  <= io_s1_reg;
		clk_s1_reg <= clk_pin;
		clk_s2_reg <= clk_s1_reg;
		clk_s3_reg <= clk_s2_reg;
	end
	// a glitchy clock pin near reset only costs an extra edge; board keeps it steady
	assign clk_rise = clk_s2_reg & ~clk_s3_reg;

	assign fb_vec = (cfg_reg.registered & state_reg) | (~cfg_reg.registered & io_s2_reg);
	assign arr_in = {fb_vec, in_s2_reg};

	genvar g;
	generate
		for (g = 0; g < `PLAM_N_ARR; g++) begin : g_line
			assign lines[2*g]   = arr_in[g];
			assign lines[2*g+1] = ~arr_in[g];
		end
		for (g = 0; g < `PLAM_N_TERM; g++) begin : g_term
			// an open cell ignores its line, so unconnected inputs cannot disturb the term
			assign term_vec[g] = &(lines | ~cell_mem[g]);
		end
		for (g = 0; g < `PLAM_N_CELL; g++) begin : g_cell
			localparam int BASE = cell_base(g);
			localparam int NSUM = sum_count(g);
			assign oe_term[g] = term_vec[BASE];
			assign sum_vec[g] = |term_vec[BASE+1 +: NSUM];
		end
	endgenerate

	assign ar_term = term_vec[`PLAM_TERM_AR];
	assign sp_term = term_vec[`PLAM_TERM_SP];

	// reset term clears the flops at the next aclk edge, no pin clock needed
	assign state_next = ar_term ? '0 :
		(clk_rise ? (sp_term ? '1 : sum_vec) : state_reg);
	assign q_vec    = (cfg_reg.registered & state_reg) | (~cfg_reg.registered & sum_vec);
	assign out_next = (cfg_reg.pol_high & q_vec) | (~cfg_reg.pol_high & ~q_vec);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
			out_reg   <= '0;
			oe_reg    <= '0;
		end else begin
			state_reg <= state_next;
			out_reg   <= out_next;
			oe_reg    <= oe_term;
		end
	end
	assign io_out = out_reg;
	assign io_oe  = oe_reg;

	// axi4-lite slave: cell words, configuration, status
	wire        aw_take = s_axi_awvalid & awready_reg;
	wire        w_take  = s_axi_wvalid & wready_reg;
	wire        wr_go   = ~awready_reg & ~wready_reg & ~bvalid_reg;
	wire        b_done  = bvalid_reg & s_axi_bready;
	wire        ar_take = s_axi_arvalid & arready_reg;
	wire        r_done  = rvalid_reg & s_axi_rready;
	wire [9:0]  wr_idx  = awaddr_reg[11:2];
	wire        wr_cell = wr_idx < `PLAM_CELL_WORDS;
	wire        wr_cfg  = awaddr_reg[11:2] == `PLAM_CFG_ADDR >> 2;
	wire        wr_stat = awaddr_reg[11:2] == `PLAM_STAT_ADDR >> 2;
	wire [7:0]  wr_term = wr_cell ? wr_idx[8:1] : 8'h00;
	plam_line_t wr_old;
	wire [31:0] wr_lo   = merge32(wr_old[31:0], wdata_reg, wstrb_reg);
	wire [31:0] wr_hi   = merge32({20'h0_0000, wr_old[43:32]}, wdata_reg, wstrb_reg);
	wire [31:0] cfg_mg  = merge32({12'h000, cfg_reg}, wdata_reg, wstrb_reg);
	plam_line_t wr_new;
	assign wr_old = cell_mem[wr_term];
	assign wr_new = wr_idx[0] ? {wr_hi[11:0], wr_old[31:0]} : {wr_old[43:32], wr_lo};

	wire [9:0]  rd_idx  = s_axi_araddr[11:2];
	wire        rd_cell = rd_idx < `PLAM_CELL_WORDS;
	wire        rd_cfg  = s_axi_araddr[11:2] == `PLAM_CFG_ADDR >> 2;
	wire        rd_stat = s_axi_araddr[11:2] == `PLAM_STAT_ADDR >> 2;
	wire [7:0]  rd_term = rd_cell ? rd_idx[8:1] : 8'h00;
	plam_line_t rd_word;
	wire [31:0] rd_data;
	assign rd_word = cell_mem[rd_term];
	assign rd_data = rd_cell ? (rd_idx[0] ? {20'h0_0000, rd_word[43:32]} : rd_word[31:0]) :
		rd_cfg ? {12'h000, cfg_reg} :
		rd_stat ? {2'b00, out_reg, oe_reg, state_reg} : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int t = 0; t < `PLAM_N_TERM; t++) begin
				cell_mem[t] <= `PLAM_CELL_RST;
			end
			cfg_reg <= `PLAM_CFG_RST;
		end else if (wr_go && wr_cell) begin
			cell_mem[wr_term] <= wr_new;
		end else if (wr_go && wr_cfg) begin
			cfg_reg <= cfg_mg[19:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `PLAM_RESP_OK;
			awaddr_reg  <= 12'h000;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
		end else begin
			if (aw_take) begin
				awready_reg <= 1'b0;
				awaddr_reg  <= s_axi_awaddr;
			end else if (b_done) begin
				awready_reg <= 1'b1;
			end
			if (w_take) begin
				wready_reg <= 1'b0;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end else if (b_done) begin
				wready_reg <= 1'b1;
			end
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= (wr_cell | wr_cfg | wr_stat) ? `PLAM_RESP_OK : `PLAM_RESP_ERR;
			end else if (b_done) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= `PLAM_RESP_OK;
			rdata_reg   <= 32'h0000_0000;
		end else if (ar_take) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_data;
			rresp_reg   <= (rd_cell | rd_cfg | rd_stat) ? `PLAM_RESP_OK : `PLAM_RESP_ERR;
		end else if (r_done) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence wr_ready_s;
		~awready_reg && ~wready_reg && ~bvalid_reg;
	endsequence
	sequence edge_preset_s;
		clk_rise && sp_term && !ar_term;
	endsequence

	power_clear_a: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> state_reg == '0) else $error("flops not cleared by reset");
	async_clear_a: assert property (ar_term |=> state_reg == '0)
		else $error("reset term did not clear flops");
	clear_wins_a: assert property (ar_term && sp_term && clk_rise |=> state_reg == '0)
		else $error("preset beat reset");
	preset_high_a: assert property (edge_preset_s |=> state_reg == '1)
		else $error("preset term did not set flops");
	edge_capture_a: assert property (clk_rise && !sp_term && !ar_term
		|=> state_reg == $past(sum_vec)) else $error("flop missed function at edge");
	hold_state_a: assert property (!clk_rise && !ar_term |=> $stable(state_reg))
		else $error("flop moved without clock edge");
	// gated on aresetn so the release edge, which still loads reset values, is not judged
	pin_enable_a: assert property (aresetn |=> io_oe == $past(oe_term))
		else $error("pin enable does not follow its term");
	pin_level_a: assert property (aresetn |=> io_out == $past(out_next)
		&& (io_out ^ $past(q_vec)) == ~$past(cfg_reg.pol_high))
		else $error("pin level wrong for polarity");
	write_resp_a: assert property (wr_ready_s |=> s_axi_bvalid)
		else $error("write not answered");
	read_resp_a: assert property (ar_take |=> s_axi_rvalid[*1] ##0 !s_axi_arready)
		else $error("read not answered");
endmodule // plam_top

// >>> bench/plam_board.sv
// board model: resolves each output cell pin as seen back by the array
`timescale 1ns/1ps
module plam_board
	import plam_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic [9:0] io_out,
	input  wire logic [9:0] io_oe,
	output logic      [9:0] io_in
);
	logic [9:0] idle_reg;
	// a released pin toggles every aclk cycle instead of holding its last driven level
	always @(posedge aclk)
		idle_reg <= (idle_reg === 10'h155) ? 10'h2aa : 10'h155;
	assign io_in = (io_oe & io_out) | (~io_oe & idle_reg);
endmodule // plam_board

// >>> bench/plam_top_tb.sv
// testbench of the logic array: programming port and pin behaviour
`timescale 1ns/1ps
`include "plam_map.svh"
module plam_top_tb import plam_pkg::*;;
	logic        aclk, aresetn, clk_pin;
	logic [11:0] s_axi_awaddr, s_axi_araddr, in_pin;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [9:0]  io_in, io_out, io_oe;
	int          n_fail, checks;
	plam_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clk_pin, .in_pin,
		.io_in, .io_out, .io_oe);
	plam_board u_board (.aclk, .io_out, .io_oe, .io_in);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic aw, w;
		@(posedge aclk);
		{aw, w} = 2'b00;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && s_axi_awready === 1'b1) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdr(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		{rd, rsp} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask
	// a term is two words: line bits 31:0, then 43:32
	task automatic term(input int t, input logic [43:0] v);
		wr(12'(8 * t), v[31:0]);
		wr(12'(8 * t + 4), {20'h0_0000, v[43:32]});
	endtask
	task automatic pin(input logic [11:0] v);
		@(posedge aclk);
		in_pin <= v;
		repeat (8) @(posedge aclk);
	endtask
	task automatic tick();
		@(posedge aclk);
		clk_pin <= 1'b1;
		repeat (5) @(posedge aclk);
		clk_pin <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask
	task automatic s_reset();
		chk("oe", io_oe, 10'h000);
		rdr(`PLAM_CFG_ADDR);
		chk("cfg", rd, 32'h0000_0000);
		chk("rresp", rsp, `PLAM_RESP_OK);
		rdr(`PLAM_STAT_ADDR);
		// flops low, pins released, active-low outputs of a false function read high
		chk("state", rd, 32'h3ff0_0000);
	endtask
	// cell 0 uses its last sum term 9; term 10 already belongs to cell 1
	task automatic s_comb();
		term(1, 44'h0);
		term(9, 44'h1);
		term(10, 44'h0);
		term(11, 44'h1 << 24);
		wr(`PLAM_CFG_ADDR, 32'h0000_0c00);
		pin(12'h000);
		chk("oe", io_oe[1:0], 2'b11);
		chk("out", io_out[1:0], 2'b00);
		pin(12'h001);
		chk("out", io_out[1:0], 2'b11);
		pin(12'h021);
		chk("out", io_out[1:0], 2'b11);
		wr(`PLAM_CFG_ADDR, 32'h0000_0800);
		repeat (8) @(posedge aclk);
		chk("out", io_out[1:0], 2'b00);
		term(9, 44'h2);
		repeat (8) @(posedge aclk);
		chk("out", io_out[1:0], 2'b11);
		term(1, `PLAM_CELL_RST);
		repeat (8) @(posedge aclk);
		chk("oe", io_oe[1:0], 2'b10);
	endtask
	// cell 0 is registered, so cell 1 follows its flop through the feedback while the cell 0 pin stays released
	task automatic s_reg();
		term(9, 44'h1);
		wr(`PLAM_CFG_ADDR, 32'h0000_0c01);
		pin(12'h001);
		chk("out", io_out[1], 1'b0);
		tick();
		chk("out", io_out[1], 1'b1);
		pin(12'h000);
		chk("out", io_out[1], 1'b1);
		tick();
		chk("out", io_out[1], 1'b0);
	endtask
	task automatic s_preset();
		wr(`PLAM_CFG_ADDR, 32'h0000_0003);
		term(131, 44'h0);
		tick();
		rdr(`PLAM_STAT_ADDR);
		chk("state", rd[9:0], 10'h3ff);
		chk("out", io_out[1], 1'b0);
		term(0, 44'h4);
		pin(12'h002);
		tick();
		rdr(`PLAM_STAT_ADDR);
		chk("state", rd[9:0], 10'h000);
		chk("out", io_out[1], 1'b1);
	endtask
	task automatic s_bus();
		wr(12'h900, 32'h0000_0001);
		chk("bresp", rsp, `PLAM_RESP_ERR);
		rdr(12'h900);
		chk("rdata", rd, 32'h0000_0000);
		chk("rresp", rsp, `PLAM_RESP_ERR);
		wr(`PLAM_STAT_ADDR, 32'hffff_ffff);
		chk("bresp", rsp, `PLAM_RESP_OK);
		rdr(12'h00c);
		chk("rdata", rd, 32'h0000_0fff);
	endtask
	task automatic final_report();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		final_report();
	end
	initial begin
		{n_fail, checks} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		in_pin = 12'h000;
		clk_pin = 1'b0;
		aresetn = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		s_reset();
		s_comb();
		s_reg();
		s_preset();
		s_bus();
		final_report();
	end
endmodule // plam_top_tb
